/* rtl/pdm_pin_mux.sv */
// module: drive state and signal selection for four multi-purpose pins, AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
module pdm_pin_mux
    import pdm_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // internal status sources
    input wire logic readback_data,
    input wire logic comparator_zero,
    input wire logic digital_lock_flag,
    input wire logic pump_voltage_monitor,
    // pins: 0 trigger one, 1 trigger two, 2 fsk/psk, 3 monitor output
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe
);
    logic [7:0] pin_cfg_reg [NUM_PINS];
    logic [7:0] ext_sel_reg;
    logic [31:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_held_reg;
    logic [3:0] raw_in;
    logic [3:0] sync_in;
    logic combined_lock_flag;
    logic [3:0] sel_signal;
    logic [3:0] pin_out_next;
    logic [3:0] pin_oe_next;
    logic do_write;
    logic [9:0] wr_addr;
    logic [9:0] rd_addr;
    logic [31:0] rd_data_next;
    logic rd_hit;

    // input synchronisers, one per pin
    // raw copies tap the second stage, so selects 1 to 3 never see the first flop
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1)
        begin : g_sync
            pdm_pin_sync u_sync
            (
                .aclk(aclk),
                .aresetn(aresetn),
                .pin_in(pin_in[gi]),
                .raw_out(raw_in[gi]),
                .sync_out(sync_in[gi])
            );
        end
    endgenerate

    // lock indication only when both monitors are good
    assign combined_lock_flag = digital_lock_flag & pump_voltage_monitor;

    // write address and data accepted independently, held until the response
    // no new half is taken while a response waits, so one write at most is open
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end
        else if (do_write)
            aw_held_reg <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end
        else if (do_write)
            w_held_reg <= 1'b0;
    end

    // both halves present: commit the write
    assign do_write = aw_held_reg && w_held_reg;
    assign wr_addr = awaddr_reg[9:0];

    // write response, error for unmapped or read-only words
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            if (awaddr_reg[31:10] == 22'h0 && (wr_addr == ADDR_EXT_SELECT
                || (wr_addr >= ADDR_PIN_CFG_BASE
                && wr_addr < ADDR_PIN_STATUS && wr_addr[1:0] == 2'b00)))
                s_axi_bresp <= RESP_OKAY;
            else
                s_axi_bresp <= RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // pin config registers, drive state and select field, reset to tristate
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1)
        begin : g_cfg
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    pin_cfg_reg[gi] <= CFG_RESET;
                else if (do_write && wstrb_reg[0] && awaddr_reg[31:10] == 22'h0
                    && wr_addr == ADDR_PIN_CFG_BASE + 10'(4 * gi))
                    pin_cfg_reg[gi] <= wdata_reg[7:0];
            end
        end
    endgenerate

    // extension select bits
    // bit 3 trigger one, bit 4 trigger two, bit 5 fsk/psk, bit 7 monitor output
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ext_sel_reg <= EXT_RESET;
        else if (do_write && wstrb_reg[0] && awaddr_reg[31:10] == 22'h0
            && wr_addr == ADDR_EXT_SELECT)
            ext_sel_reg <= wdata_reg[7:0];
    end

    // read channel
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_addr = s_axi_araddr[9:0];

    // read decode
    always_comb
    begin
        rd_data_next = 32'h0000_0000;
        rd_hit = 1'b1;
        // an address above the register window reads zero before any decode
        if (s_axi_araddr[31:10] != 22'h0)
            rd_hit = 1'b0;
        else if (rd_addr == ADDR_EXT_SELECT)
            rd_data_next[7:0] = ext_sel_reg;
        else if (rd_addr == ADDR_PIN_STATUS)
            rd_data_next[11:0] = {pin_oe, pin_out, sync_in};
        else if (rd_addr >= ADDR_PIN_CFG_BASE && rd_addr < ADDR_PIN_STATUS
            && rd_addr[1:0] == 2'b00)
            rd_data_next[7:0] = pin_cfg_reg[rd_addr[3:2]];
        else
            rd_hit = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data_next;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // per pin: signal selection then drive state
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1)
        begin : g_pin
            logic [5:0] sel;
            logic [2:0] drive;

            // six-bit select from config field and extension bit
            assign sel = {|(ext_sel_reg & EXT_BIT_POS[8*gi +: 8]),
                pin_cfg_reg[gi][SEL_MSB:SEL_LSB]};
            assign drive = pin_cfg_reg[gi][DRIVE_MSB:DRIVE_LSB];

            // source multiplexer
            always_comb
            begin
                case (sel)
                    SEL_GROUND: sel_signal[gi] = 1'b0;
                    SEL_RAW_TRIG_ONE: sel_signal[gi] = raw_in[0];
                    SEL_RAW_TRIG_TWO: sel_signal[gi] = raw_in[1];
                    SEL_RAW_FSK_PSK: sel_signal[gi] = raw_in[2];
                    SEL_SYNC_TRIG_ONE: sel_signal[gi] = sync_in[0];
                    SEL_SYNC_TRIG_TWO: sel_signal[gi] = sync_in[1];
                    SEL_SYNC_FSK_PSK: sel_signal[gi] = sync_in[2];
                    SEL_READBACK: sel_signal[gi] = readback_data;
                    SEL_COMPARATOR_ZERO: sel_signal[gi] = comparator_zero;
                    SEL_COMBINED_LOCK: sel_signal[gi] = combined_lock_flag;
                    SEL_DIGITAL_LOCK: sel_signal[gi] = digital_lock_flag;
                    SEL_PUMP_GOOD: sel_signal[gi] = pump_voltage_monitor;
                    // unlisted selects read as ground so a stray code drives nothing live
                    default: sel_signal[gi] = 1'b0;
                endcase
            end

            // drive state decode into level and enable
            always_comb
            begin
                case (drive)
                    DRV_OPEN_DRAIN:
                    begin
                        pin_out_next[gi] = 1'b0;
                        pin_oe_next[gi] = !sel_signal[gi];
                    end
                    DRV_PUSH_PULL:
                    begin
                        pin_out_next[gi] = sel_signal[gi];
                        pin_oe_next[gi] = 1'b1;
                    end
                    DRV_GROUND:
                    begin
                        pin_out_next[gi] = 1'b0;
                        pin_oe_next[gi] = 1'b1;
                    end
                    DRV_INV_OPEN_DRAIN:
                    begin
                        pin_out_next[gi] = 1'b0;
                        pin_oe_next[gi] = sel_signal[gi];
                    end
                    DRV_INV_PUSH_PULL:
                    begin
                        pin_out_next[gi] = !sel_signal[gi];
                        pin_oe_next[gi] = 1'b1;
                    end
                    default:
                    begin
                        // tristate, reserved and input all release the pin
                        pin_out_next[gi] = 1'b0;
                        pin_oe_next[gi] = 1'b0;
                    end
                endcase
            end
        end
    endgenerate

    // registered pin drivers
    // the flop keeps a select change from glitching a pad through the decode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_out <= 4'h0;
            pin_oe <= 4'h0;
        end
        else
        begin
            pin_out <= pin_out_next;
            pin_oe <= pin_oe_next;
        end
    end
endmodule
`default_nettype wire

/* rtl/pdm_pkg.sv */
// package: register map, field layout and encodings of the pin drive and mux block
package pdm_pkg;
    // register indices and byte addresses (byte address is four times the index)
    localparam logic [7:0] IDX_EXT_SELECT = 8'h23;
    localparam logic [7:0] IDX_TRIG_ONE = 8'h24;
    localparam logic [7:0] IDX_TRIG_TWO = 8'h25;
    localparam logic [7:0] IDX_FSK_PSK = 8'h26;
    localparam logic [7:0] IDX_MONITOR = 8'h27;
    localparam logic [7:0] IDX_PIN_STATUS = 8'h28;
    localparam logic [9:0] ADDR_EXT_SELECT = {IDX_EXT_SELECT, 2'b00};
    localparam logic [9:0] ADDR_PIN_CFG_BASE = {IDX_TRIG_ONE, 2'b00};
    localparam logic [9:0] ADDR_PIN_STATUS = {IDX_PIN_STATUS, 2'b00};
    localparam int NUM_PINS = 4;
    // field layout
    localparam int DRIVE_LSB = 0;
    localparam int DRIVE_MSB = 2;
    localparam int SEL_LSB = 3;
    localparam int SEL_MSB = 7;
    localparam logic [31:0] EXT_BIT_POS = 32'h80_20_10_08; // ext bit mask per pin, one byte each
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] EXT_RESET = 8'h00;
    // drive states
    localparam logic [2:0] DRV_TRISTATE = 3'h0;
    localparam logic [2:0] DRV_OPEN_DRAIN = 3'h1;
    localparam logic [2:0] DRV_PUSH_PULL = 3'h2;
    localparam logic [2:0] DRV_RESERVED = 3'h3;
    localparam logic [2:0] DRV_GROUND = 3'h4;
    localparam logic [2:0] DRV_INV_OPEN_DRAIN = 3'h5;
    localparam logic [2:0] DRV_INV_PUSH_PULL = 3'h6;
    localparam logic [2:0] DRV_INPUT = 3'h7;
    // selection codes
    localparam logic [5:0] SEL_GROUND = 6'h00;
    localparam logic [5:0] SEL_RAW_TRIG_ONE = 6'h01;
    localparam logic [5:0] SEL_RAW_TRIG_TWO = 6'h02;
    localparam logic [5:0] SEL_RAW_FSK_PSK = 6'h03;
    localparam logic [5:0] SEL_SYNC_TRIG_ONE = 6'h04;
    localparam logic [5:0] SEL_SYNC_TRIG_TWO = 6'h05;
    localparam logic [5:0] SEL_SYNC_FSK_PSK = 6'h06;
    localparam logic [5:0] SEL_READBACK = 6'h07;
    localparam logic [5:0] SEL_COMPARATOR_ZERO = 6'h08;
    localparam logic [5:0] SEL_COMBINED_LOCK = 6'h0a;
    localparam logic [5:0] SEL_DIGITAL_LOCK = 6'h0b;
    localparam logic [5:0] SEL_PUMP_GOOD = 6'h0c;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* rtl/pdm_pin_sync.sv */
// module: three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ns
`default_nettype none
module pdm_pin_sync
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pin side
    input wire logic pin_in,
    // clock side
    output logic raw_out,
    output logic sync_out
);
    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;

    // shift chain, first stage feeds only the second
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
        end
        else
        begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // filtered copy changes once stages two and three agree
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sync_out <= 1'b0;
        else if (stage2_reg == stage3_reg)
            sync_out <= stage3_reg;
    end

    assign raw_out = stage2_reg;
endmodule
`default_nettype wire

/* verification/pdm_pin_partner.sv */
// partner: pull-up and external drivers on the four pins
`timescale 1ns/1ns
`default_nettype none
module pdm_pin_partner
(
    // device side
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    // external drivers
    input wire logic [3:0] ext_en,
    input wire logic [3:0] ext_val,
    // resolved level
    output logic [3:0] pin_in
);
    // device drive wins, then the external driver, else the pull-up
    always_comb
        for (int i = 0; i < 4; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
endmodule
`default_nettype wire

/* verification/pdm_pin_mux_checker.sv */
// checker: bus answers and pin drive states at the mux ports
`timescale 1ns/1ns
`default_nettype none
module pdm_pin_mux_checker
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [31:0] aw_q;
    logic [2:0] dq;
    logic ws_q;
    logic [1:0] pi;
    // capture address and drive field as they are taken
    always_ff @(posedge aclk)
    begin
        if (s_axi_awvalid && s_axi_awready)
            aw_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
        begin
            dq <= s_axi_wdata[2:0];
            ws_q <= s_axi_wstrb[0];
        end
    end
    assign pi = aw_q[3:2]; // pin index of a config write
    sequence pin_commit;
        $rose(s_axi_bvalid) && aw_q[11:4] == 8'h09 && ws_q;
    endsequence
    reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> pin_oe == 4'h0
        && !s_axi_bvalid && !s_axi_rvalid) else $error("pins or answers not cleared by reset");
    ground_drive_a: assert property (pin_commit ##0 dq == 3'h4 |=> pin_oe[pi] && !pin_out[pi])
        else $error("ground drive state not pulling low");
    pin_release_a: assert property (pin_commit ##0 (dq == 3'h0 || dq == 3'h3 || dq == 3'h7)
        |=> !pin_oe[pi]) else $error("released drive state still driving");
    push_pull_a: assert property (pin_commit ##0 (dq == 3'h2 || dq == 3'h6) |=> pin_oe[pi])
        else $error("push-pull pin not driven");
    open_drain_a: assert property (pin_commit ##0 (dq == 3'h1 || dq == 3'h5) |=> !pin_out[pi])
        else $error("open-drain pin drives high");
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // the response comes one cycle after the commit, two after both halves are taken
    write_answer_a: assert property (write_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    bvalid_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not cleared after acceptance");
    rvalid_clear_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not cleared after acceptance");
endmodule
`default_nettype wire

/* verification/tb.sv */
// testbench: registers, drive states and selections of the pin mux
`timescale 1ns/1ns
`default_nettype none
module tb;
    import pdm_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, e, m;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_bvalid, s_axi_rvalid, s_axi_awready, s_axi_wready;
    logic s_axi_arready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] st = 4'h0, ext_en = 4'h0, ext_val = 4'h0, pin_in, pin_out, pin_oe;
    logic [15:0] rnd = 16'hefcf;
    logic [5:0] sl[14] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 6'h2a};
    logic [33:0] rq[$];
    logic [31:0] mq[$];
    logic [1:0] bq[$];
    int fails = 0, checked = 0, cyc = 0;
    always #25 aclk = ~aclk;
    pdm_pin_mux u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .readback_data(st[3]),
        .comparator_zero(st[2]), .digital_lock_flag(st[1]), .pump_voltage_monitor(st[0]),
        .pin_in, .pin_out, .pin_oe);
    pdm_pin_partner u_far (.pin_out, .pin_oe, .ext_en, .ext_val, .pin_in);
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // expected {oe, out} of a pin for drive d and selected level s
    function automatic logic [1:0] pin_exp(input logic [2:0] d, input logic s);
        case (d)
            3'h1: return {~s, 1'b0};
            3'h2: return {1'b1, s};
            3'h4: return 2'b10;
            3'h5: return {s, 1'b0};
            3'h6: return {1'b1, ~s};
            default: return 2'b00;
        endcase
    endfunction
    // expected level of selection s from pins v and status t
    function automatic logic src(input logic [5:0] s, input logic [3:0] v, input logic [3:0] t);
        case (s)
            6'h01, 6'h04: return v[0];
            6'h02, 6'h05: return v[1];
            6'h03, 6'h06: return v[2];
            6'h07: return t[3];
            6'h08: return t[2];
            6'h0a: return t[1] & t[0];
            6'h0b: return t[1];
            6'h0c: return t[0];
            default: return 1'b0;
        endcase
    endfunction
    // one write; ready is looked at mid-cycle, where it equals its value at the next edge
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, tv;
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tv = s_axi_bvalid;
            @(posedge aclk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
        end while (tv !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    // one read, with the expected word and its compare mask noted
    task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic [31:0] k,
        input logic [1:0] r);
        logic ta, tv;
        rq.push_back({r, x});
        mq.push_back(k);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ta = s_axi_arready;
            tv = s_axi_rvalid;
            @(posedge aclk);
            if (ta)
                s_axi_arvalid <= 1'b0;
        end while (tv !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask
    task automatic cmp_resp(input logic [1:0] g);
        logic [1:0] n;
        n = bq.pop_front();
        checked++;
        if (g !== n)
        begin
            fails++;
            $display("BAD %0t bresp %h expected %h", $time, g, n);
        end
    endtask
    task automatic cmp_read(input logic [31:0] g, input logic [1:0] gr);
        logic [33:0] n;
        logic [31:0] k;
        n = rq.pop_front();
        k = mq.pop_front();
        checked++;
        if ((g & k) !== (n[31:0] & k) || gr !== n[33:32])
        begin
            fails++;
            $display("BAD %0t read %h expected %h", $time, g, n[31:0]);
        end
    endtask
    task automatic close_out;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watch the answers and compare them against the oldest note
    always @(posedge aclk)
    begin
        cyc++;
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
            cmp_resp(s_axi_bresp);
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
            cmp_read(s_axi_rdata, s_axi_rresp);
        if (cyc == 6000)
        begin
            fails++;
            close_out;
        end
    end
    // main sequence
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd(ADDR_EXT_SELECT + 4 * i, 32'h0, 32'hffffffff, RESP_OKAY);
        rd(ADDR_PIN_STATUS, 32'h0, 32'hf00, RESP_OKAY);
        for (int d = 0; d < 8; d++)
            for (int s = 0; s < 2; s++)
            begin
                st[2] <= s[0];
                e = 32'h0;
                m = 32'hf00;
                for (int p = 0; p < 4; p++)
                begin
                    wr(ADDR_PIN_CFG_BASE + 4 * p, {24'h0, 5'h08, d[2:0]}, RESP_OKAY);
                    rd(ADDR_PIN_CFG_BASE + 4 * p, {24'h0, 5'h08, d[2:0]}, '1, RESP_OKAY);
                    {e[8 + p], e[4 + p]} = pin_exp(d[2:0], s[0]);
                    m[4 + p] = !(d inside {0, 3, 7});
                end
                rd(ADDR_PIN_STATUS, e, m, RESP_OKAY);
            end
        for (int p = 0; p < 3; p++)
            wr(ADDR_PIN_CFG_BASE + 4 * p, 32'h7, RESP_OKAY);
        ext_en <= 4'h7;
        for (int k = 0; k < 14; k++)
        begin
            rnd = lfsr(rnd);
            ext_val <= rnd[3:0];
            st <= rnd[7:4];
            wr(ADDR_EXT_SELECT, {24'h0, sl[k][5], 7'h0}, RESP_OKAY);
            wr(32'h9c, {24'h0, sl[k][4:0], 3'h2}, RESP_OKAY);
            repeat (6) @(posedge aclk);
            e = {20'h0, 4'h8, src(sl[k], rnd[3:0], rnd[7:4]), 3'h0, 1'b0, rnd[2:0]};
            rd(ADDR_PIN_STATUS, e, 32'h887, RESP_OKAY);
        end
        wr(32'h200, 32'h5, RESP_SLVERR);
        rd(32'h200, 32'h0, '1, RESP_SLVERR);
        wr(ADDR_PIN_STATUS, 32'h0, RESP_SLVERR);
        s_axi_wstrb <= 4'h0;
        wr(32'h9c, 32'hff, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(32'h9c, {24'h0, sl[13][4:0], 3'h2}, '1, RESP_OKAY);
        close_out;
    end
endmodule
bind pdm_pin_mux pdm_pin_mux_checker u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .pin_out, .pin_oe);
`default_nettype wire
